// file: rtl/dma_params.svh
// register map, field positions and reset values of the dma channel
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFS_CMD      8'h00
`define OFS_LOW      8'h04
`define OFS_CTRL     8'h08
`define OFS_ADDR     8'h0C
`define OFS_COUNT    8'h10
`define OFS_STATE    8'h14
`define OFS_STS      8'h18
`define OFS_CLR      8'h1C
`define OFS_EN       8'h20

// ==========================================================
// command register bits
`define CMD_LO_SET    0
`define CMD_LO_CLR    1
`define CMD_HI_SETCLF 2
`define CMD_HI_CLR    3

// ==========================================================
// control word and address word fields
`define CW_SEL_HI    5
`define CW_CLR_BIT   13
`define CW_PACK_BIT  14
`define CW_SET_BIT   15
`define DIR_BIT      15

// ==========================================================
// event bits, reset values, constants
`define EV_DONE      0
`define EV_WORD      1
`define RST_WORD     16'h0000
`define RST_EV       2'h0
`define RST_BUS      32'h0000_0000
`define CNT_LAST     16'hFFFF
`define CNT_STEP     16'h0001
`define ADR_STEP     15'h0001
`define CHAR_PAD     8'h00

`endif

// file: rtl/dma_pkg.sv
// types shared by the dma channel modules
package dma_pkg;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_WAIT  = 5'b00010,
      ST_FETCH = 5'b00100,
      ST_SEND  = 5'b01000,
      ST_STORE = 5'b10000
   } state_e;

   typedef struct packed {
      state_e      st;
      logic        armed;
      logic        sw;
      logic        flag;
      logic        half;
      logic [15:0] ctl;
      logic [15:0] adr;
      logic [15:0] cnt;
      logic [15:0] word;
      logic [15:0] dout;
      logic [7:0]  hi;
      logic [1:0]  sts;
      logic [1:0]  en;
      logic        set_p;
      logic        clr_p;
      logic        clf_p;
      logic [31:0] rdata;
   } chan_s;

   typedef struct packed {
      logic [2:0] sh;
      logic       level;
      logic       rise;
   } sync_s;

endpackage : dma_pkg

// file: rtl/flag_if.sv
// synchronised device flag passed from the synchroniser to the channel
`timescale 1ns/1ps
interface flag_if;
   logic level;
   logic rise;
   modport src (output level, output rise);
   modport dst (input level, input rise);
endinterface : flag_if

// file: rtl/flag_sync.sv
// three-stage synchroniser for the device flag pin
`timescale 1ns/1ps
module flag_sync
   import dma_pkg::*;
(
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic flag_pin_in,
   flag_if.src       fl
);
   import dma_pkg::*;

   sync_s r_ff;
   sync_s nxt_r;

   always_comb begin
      nxt_r       = r_ff;
      nxt_r.sh    = {r_ff.sh[1:0], flag_pin_in};
      nxt_r.rise  = 1'b0;
      // level follows only when stages two and three agree
      if (r_ff.sh[1] == r_ff.sh[2]) begin
         nxt_r.level = r_ff.sh[2];
         nxt_r.rise  = r_ff.sh[2] & ~r_ff.level;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign fl.level = r_ff.level;
   assign fl.rise  = r_ff.rise;

endmodule : flag_sync

// file: rtl/dma_channel.sv
// one dma channel: apb registers, device handshake and memory access
`timescale 1ns/1ps
`include "dma_params.svh"
module dma_channel
   import dma_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        dev_flag_in,
   input  wire logic [15:0] dev_data_in,
   output logic      [15:0] dev_data_out,
   output logic      [5:0]  dev_select_code_out,
   output logic             dev_set_ctl_out,
   output logic             dev_clr_ctl_out,
   output logic             dev_clr_flag_out,
   output logic             mem_req_out,
   output logic             mem_we_out,
   output logic      [14:0] mem_addr_out,
   output logic      [15:0] mem_wdata_out,
   input  wire logic [15:0] mem_rdata_in,
   input  wire logic        mem_ack_in,
   output logic             irq_out
);
   import dma_pkg::*;

   // ==========================================================
   // device flag synchroniser
   flag_if fl ();

   flag_sync u_sync (
      .sys_clk_in  (sys_clk_in),
      .rst_n_in    (rst_n_in),
      .flag_pin_in (dev_flag_in),
      .fl          (fl.src)
   );

   // ==========================================================
   // state
   chan_s       r_ff;
   chan_s       nxt_r;
   logic        wr;
   logic        mapped;
   logic        is_in;
   logic        pack;
   logic        fin;
   logic [1:0]  ev;
   logic [31:0] rd_mux;

   assign is_in = r_ff.adr[`DIR_BIT];
   assign pack  = r_ff.ctl[`CW_PACK_BIT];
   assign wr    = psel_in & penable_in & pwrite_in;

   always_comb begin
      mapped = 1'b1;
      rd_mux = `RST_BUS;
      case (paddr_in)
         `OFS_CMD:   rd_mux = `RST_BUS;
         `OFS_LOW:   rd_mux = `RST_BUS;
         `OFS_CTRL:  rd_mux = {16'h0000, r_ff.ctl};
         `OFS_ADDR:  rd_mux = {16'h0000, r_ff.adr};
         `OFS_COUNT: rd_mux = {16'h0000, r_ff.cnt};
         `OFS_STATE: rd_mux = {28'h0000000, ~r_ff.st[0], r_ff.flag, r_ff.sw, r_ff.armed};
         `OFS_STS:   rd_mux = {30'h0000000, r_ff.sts};
         `OFS_CLR:   rd_mux = `RST_BUS;
         `OFS_EN:    rd_mux = {30'h0000000, r_ff.en};
         default:    mapped = 1'b0;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      nxt_r       = r_ff;
      nxt_r.set_p = 1'b0;
      nxt_r.clr_p = 1'b0;
      nxt_r.clf_p = 1'b0;
      fin         = 1'b0;
      ev          = `RST_EV;
      // read data latched in the setup cycle
      if (psel_in && !penable_in) begin
         nxt_r.rdata = rd_mux;
      end
      case (r_ff.st)
         ST_IDLE: begin
            nxt_r.half = 1'b0;
         end
         ST_WAIT: begin
            if (fl.rise) begin
               if (is_in) begin
                  if (pack && !r_ff.half) begin
                     nxt_r.hi   = dev_data_in[7:0];
                     nxt_r.half = 1'b1;
                     if (r_ff.ctl[`CW_SET_BIT]) begin
                        nxt_r.set_p = 1'b1;
                        nxt_r.clf_p = 1'b1;
                     end
                  end else begin
                     nxt_r.word = pack ? {r_ff.hi, dev_data_in[7:0]}
                                       : dev_data_in;
                     nxt_r.st   = ST_STORE;
                  end
               end else begin
                  nxt_r.st = (pack && r_ff.half) ? ST_SEND : ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            if (mem_ack_in) begin
               nxt_r.word = mem_rdata_in;
               nxt_r.st   = ST_SEND;
            end
         end
         ST_SEND: begin
            nxt_r.set_p = 1'b1;
            nxt_r.clf_p = 1'b1;
            if (pack) begin
               nxt_r.dout = r_ff.half ? {`CHAR_PAD, r_ff.word[7:0]}
                                      : {`CHAR_PAD, r_ff.word[15:8]};
            end else begin
               nxt_r.dout = r_ff.word;
            end
            nxt_r.st = ST_WAIT;
            if (pack && !r_ff.half) begin
               nxt_r.half = 1'b1;
            end else begin
               nxt_r.half = 1'b0;
               nxt_r.adr  = {r_ff.adr[`DIR_BIT], r_ff.adr[14:0] + `ADR_STEP};
               nxt_r.cnt  = r_ff.cnt + `CNT_STEP;
               ev[`EV_WORD] = 1'b1;
               fin = (r_ff.cnt == `CNT_LAST);
            end
         end
         ST_STORE: begin
            if (mem_ack_in) begin
               nxt_r.half = 1'b0;
               nxt_r.adr  = {r_ff.adr[`DIR_BIT], r_ff.adr[14:0] + `ADR_STEP};
               nxt_r.cnt  = r_ff.cnt + `CNT_STEP;
               ev[`EV_WORD] = 1'b1;
               fin = (r_ff.cnt == `CNT_LAST);
               nxt_r.st = ST_WAIT;
               if (!fin && r_ff.ctl[`CW_SET_BIT]) begin
                  nxt_r.set_p = 1'b1;
                  nxt_r.clf_p = 1'b1;
               end
            end
         end
         default: begin
            nxt_r.st = ST_IDLE;
         end
      endcase
      // final word: disarm and raise completion
      if (fin) begin
         nxt_r.armed = 1'b0;
         nxt_r.st    = ST_IDLE;
         ev[`EV_DONE] = 1'b1;
         nxt_r.clr_p = r_ff.ctl[`CW_CLR_BIT];
      end

      // register writes
      if (wr) begin
         case (paddr_in)
            `OFS_CMD: begin
               if (pwdata_in[`CMD_LO_SET]) begin
                  nxt_r.sw = 1'b1;
               end
               if (pwdata_in[`CMD_LO_CLR]) begin
                  nxt_r.sw = 1'b0;
               end
               if (pwdata_in[`CMD_HI_CLR]) begin
                  nxt_r.armed = 1'b0;
                  nxt_r.st    = ST_IDLE;
               end else if (pwdata_in[`CMD_HI_SETCLF]) begin
                  nxt_r.flag = 1'b0;
                  if (!r_ff.armed) begin
                     nxt_r.armed = 1'b1;
                     nxt_r.half  = 1'b0;
                     nxt_r.st    = is_in ? ST_WAIT : ST_FETCH;
                  end
               end
            end
            `OFS_LOW: begin
               if (r_ff.sw) begin
                  nxt_r.cnt = pwdata_in[15:0];
               end else begin
                  nxt_r.adr = pwdata_in[15:0];
               end
            end
            `OFS_CTRL: nxt_r.ctl = pwdata_in[15:0];
            `OFS_EN:   nxt_r.en  = pwdata_in[1:0];
            default: begin
            end
         endcase
      end

      // sticky events, set wins over clear
      nxt_r.sts = r_ff.sts;
      if (wr && paddr_in == `OFS_CLR) begin
         nxt_r.sts = r_ff.sts & ~pwdata_in[1:0];
      end
      nxt_r.sts = nxt_r.sts | ev;
      if (fin) begin
         nxt_r.flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         r_ff     <= '0;
         r_ff.st  <= ST_IDLE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ==========================================================
   // outputs
   // zero wait states: every access ends at once
   assign pready_out          = 1'b1;
   assign pslverr_out         = psel_in & penable_in & ~mapped;
   assign prdata_out          = r_ff.rdata;
   assign dev_data_out        = r_ff.dout;
   assign dev_select_code_out = r_ff.ctl[`CW_SEL_HI:0];
   assign dev_set_ctl_out     = r_ff.set_p;
   assign dev_clr_ctl_out     = r_ff.clr_p;
   assign dev_clr_flag_out    = r_ff.clf_p;
   assign mem_req_out         = r_ff.st[2] | r_ff.st[4];
   assign mem_we_out          = r_ff.st[4];
   assign mem_addr_out        = r_ff.adr[14:0];
   assign mem_wdata_out       = r_ff.word;
   assign irq_out             = |(r_ff.sts & r_ff.en);

   // ==========================================================
   // assertions
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   a_count_load:
      assert property (wr && paddr_in == `OFS_LOW && r_ff.sw
                       |=> r_ff.cnt == $past(pwdata_in[15:0]))
      else $error("count not loaded with switch set");

   a_addr_load:
      assert property (wr && paddr_in == `OFS_LOW && !r_ff.sw
                       |=> r_ff.adr == $past(pwdata_in[15:0]))
      else $error("address not loaded with switch clear");

   a_arm_cmd:
      assert property (wr && paddr_in == `OFS_CMD && pwdata_in[`CMD_HI_SETCLF]
                       && !pwdata_in[`CMD_HI_CLR] && !r_ff.armed
                       |=> r_ff.armed && !r_ff.st[0])
      else $error("channel not armed by command");

   a_dir_write:
      assert property (mem_req_out |-> mem_we_out == r_ff.adr[`DIR_BIT])
      else $error("memory direction disagrees with direction bit");

   a_done_flag:
      assert property ($rose(r_ff.sts[`EV_DONE]) |-> r_ff.flag && !r_ff.armed)
      else $error("completion without channel flag");

   a_irq_flag:
      assert property ($rose(r_ff.flag) && r_ff.en[`EV_DONE] |-> irq_out)
      else $error("enabled completion raised no interrupt");

   a_clr_final:
      assert property (dev_clr_ctl_out |-> $rose(r_ff.flag) && r_ff.ctl[`CW_CLR_BIT])
      else $error("clear-control outside final transfer");

   a_out_set:
      assert property (r_ff.st == ST_SEND |=> dev_set_ctl_out ##1 !dev_set_ctl_out)
      else $error("output transfer issued no set-control");

   a_in_flag:
      assert property (r_ff.st == ST_WAIT && fl.rise && is_in && !pack
                       |=> r_ff.st == ST_STORE)
      else $error("input flag did not start a transfer");

   a_count_step:
      assert property (r_ff.st == ST_STORE && mem_ack_in
                       |=> r_ff.cnt == $past(r_ff.cnt) + `CNT_STEP)
      else $error("count did not step after word");

   a_addr_step:
      assert property (r_ff.st == ST_STORE && mem_ack_in && !wr
                       |=> r_ff.adr[14:0] == $past(r_ff.adr[14:0]) + `ADR_STEP)
      else $error("address did not step after word");

   a_in_restart:
      assert property (r_ff.st == ST_STORE && mem_ack_in && r_ff.ctl[`CW_SET_BIT]
                       && r_ff.cnt != `CNT_LAST |=> dev_set_ctl_out && dev_clr_flag_out)
      else $error("input transfer not followed by set-control");

   a_out_start:
      assert property (wr && paddr_in == `OFS_CMD && pwdata_in[`CMD_HI_SETCLF]
                       && !pwdata_in[`CMD_HI_CLR] && !r_ff.armed && !is_in
                       |=> r_ff.st == ST_FETCH && mem_req_out && !mem_we_out)
      else $error("output arm did not start a memory read");

   a_pack_first:
      assert property (r_ff.st == ST_WAIT && fl.rise && is_in && pack && !r_ff.half
                       |=> r_ff.half && r_ff.hi == $past(dev_data_in[7:0]))
      else $error("first packed character not kept high");

   a_pack_send:
      assert property (r_ff.st == ST_SEND && pack && !r_ff.half
                       |=> dev_data_out == {`CHAR_PAD, $past(r_ff.word[15:8])})
      else $error("packed output did not send high character first");

   a_clr_set:
      assert property (dev_clr_ctl_out && !is_in |-> dev_set_ctl_out)
      else $error("clear-control not with final output set-control");

   c_input_done:  cover property (is_in && $rose(r_ff.flag));
   c_output_done: cover property (!is_in && $rose(r_ff.flag));
   c_pack_store:  cover property (pack && r_ff.st == ST_STORE && mem_ack_in);
   c_clr_issued:  cover property (dev_clr_ctl_out);
   c_pack_send:   cover property (pack && !is_in && r_ff.st == ST_SEND);

endmodule : dma_channel

// file: verification/dev_card_model.sv
// behavioural peripheral card on the far side of the dma channel
`timescale 1ns/1ps
module dev_card_model (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        set_ctl_in,
   input  wire logic        clr_ctl_in,
   input  wire logic        clr_flag_in,
   input  wire logic        start_in,
   input  wire logic [7:0]  delay_in,
   input  wire logic [15:0] word_in,
   output logic             flag_out,
   output logic      [15:0] word_out
);
   logic        ctl;
   logic [15:0] word;
   logic [15:0] got [0:255];
   int          wait_cnt, ops, sets, clrs, both;
   // ==========================================
   // device operation
   // released data lines show the inverse of the last word
   assign word_out = flag_out ? word : ~word;
   always @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ctl <= 1'b0;
         flag_out <= 1'b0;
         word <= 16'h3C5A;
         ops <= 0;
         sets <= 0;
         clrs <= 0;
         both <= 0;
         wait_cnt <= 0;
      end else begin
         sets <= sets + int'(set_ctl_in);
         clrs <= clrs + int'(clr_ctl_in);
         both <= both + int'(set_ctl_in && clr_ctl_in);
         if (set_ctl_in) begin
            got[ops[7:0]] <= word_in;
         end
         if (clr_flag_in || start_in) begin
            flag_out <= 1'b0;
         end
         if (clr_ctl_in) begin
            ctl <= 1'b0;
         end else if (set_ctl_in || start_in) begin
            ctl <= 1'b1;
            wait_cnt <= 0;
         end else if (ctl && wait_cnt >= int'(delay_in)) begin
            ctl <= 1'b0;
            flag_out <= 1'b1;
            word <= 16'h3C5A + 16'(ops) * 16'h0111;
            ops <= ops + 1;
         end else if (ctl) begin
            wait_cnt <= wait_cnt + 1;
         end
      end
   end
endmodule : dev_card_model

// file: verification/testbench.sv
// self-checking bench of the dma channel with a card model and a memory
`timescale 1ns/1ps
`include "dma_params.svh"
module testbench;
   import dma_pkg::*;
   logic        clk, pready, perr, flag, mreq, mwe, irq, set_ctl, clr_ctl, clr_flag, err;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic        start = 1'b0;
   logic        mack = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [7:0]  dly = 8'h01;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic [15:0] dout, din, mwdata;
   logic [15:0] mrdata = 16'h0000;
   logic [14:0] maddr;
   logic [5:0]  sel;
   logic [15:0] mem [0:63];
   int          failures, comparisons, s0, c0, k0, b0;
   dma_channel u_dma_channel (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .dev_flag_in(flag),
      .dev_data_in(din), .dev_data_out(dout), .dev_select_code_out(sel),
      .dev_set_ctl_out(set_ctl), .dev_clr_ctl_out(clr_ctl), .dev_clr_flag_out(clr_flag),
      .mem_req_out(mreq), .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwdata),
      .mem_rdata_in(mrdata), .mem_ack_in(mack), .irq_out(irq));
   dev_card_model u_dev_card_model (.sys_clk_in(clk), .rst_n_in(rst_n), .set_ctl_in(set_ctl),
      .clr_ctl_in(clr_ctl), .clr_flag_in(clr_flag), .start_in(start), .delay_in(dly),
      .word_in(dout), .flag_out(flag), .word_out(din));
   // ==========================================
   // clock and memory
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // one-cycle ack; read lines toggle outside it
   always @(posedge clk) begin
      mack <= mreq && !mack;
      mrdata <= ~mrdata;
      if (mreq && !mack) begin
         mrdata <= mem[maddr[5:0]];
         if (mwe) begin
            mem[maddr[5:0]] <= mwdata;
         end
      end
   end
   // ==========================================
   // shared tasks
   function automatic logic [15:0] dev_word(input int k);
      return 16'h3C5A + 16'(k) * 16'h0111;
   endfunction : dev_word
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rdc
   task automatic start_device();
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask : start_device
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         apb(1'b0, `OFS_STATE, 32'h0000_0000);
         n++;
      end while (rd[2] !== 1'b1 && n < 400);
      check(rd[2], 1'b1);
   endtask : wait_done
   task automatic setup(input logic [15:0] cw, adr, cnt, input logic [7:0] d);
      dly <= d;
      wr(`OFS_CTRL, {16'h0000, cw});
      wr(`OFS_CMD, 32'h0000_0002);
      wr(`OFS_LOW, {16'h0000, adr});
      wr(`OFS_CMD, 32'h0000_0001);
      wr(`OFS_LOW, {16'h0000, cnt});
      rdc(`OFS_ADDR, {16'h0000, adr});
      rdc(`OFS_COUNT, {16'h0000, cnt});
      s0 = u_dev_card_model.sets;
      c0 = u_dev_card_model.clrs;
      k0 = u_dev_card_model.ops;
      b0 = u_dev_card_model.both;
   endtask : setup
   // ==========================================
   // scenarios
   task automatic test_regs();
      rdc(`OFS_CTRL, 32'h0000_0000);
      rdc(`OFS_STATE, 32'h0000_0000);
      rdc(`OFS_STS, 32'h0000_0000);
      wr(`OFS_CTRL, 32'h0000_E03F);
      rdc(`OFS_CTRL, 32'h0000_E03F);
      wr(`OFS_CMD, 32'h0000_0001);
      rdc(`OFS_STATE, 32'h0000_0002);
      wr(`OFS_CMD, 32'h0000_0002);
      rdc(`OFS_STATE, 32'h0000_0000);
      apb(1'b0, 8'h40, 32'h0000_0000);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
      $display("test registers done");
   endtask : test_regs
   task automatic test_input();
      wr(`OFS_EN, 32'h0000_0003);
      setup(16'hA00D, 16'h8010, 16'hFFFD, 8'h1E);
      start_device();
      wr(`OFS_CMD, 32'h0000_0004);
      wait_done();
      for (int i = 0; i < 3; i++) begin
         check({16'h0000, mem[16 + i]}, {16'h0000, dev_word(k0 + i)});
      end
      rdc(`OFS_COUNT, 32'h0000_0000);
      rdc(`OFS_ADDR, 32'h0000_8013);
      rdc(`OFS_STS, 32'h0000_0003);
      check(irq, 1'b1);
      check(sel, 6'h0D);
      check(u_dev_card_model.sets - s0, 2);
      check(u_dev_card_model.clrs - c0, 1);
      wr(`OFS_CMD, 32'h0000_0008);
      wr(`OFS_CLR, 32'h0000_0003);
      start_device();
      repeat (60) @(posedge clk);
      rdc(`OFS_STS, 32'h0000_0000);
      check(irq, 1'b0);
      $display("test input done");
   endtask : test_input
   task automatic test_output();
      mem[32] = 16'hA5A5;
      mem[33] = 16'h5A5A;
      wr(`OFS_EN, 32'h0000_0000);
      setup(16'h0011, 16'h0020, 16'hFFFE, 8'h01);
      wr(`OFS_CMD, 32'h0000_0004);
      wait_done();
      for (int n = 0; n < 100 && flag !== 1'b1; n++) begin
         @(posedge clk);
      end
      check(u_dev_card_model.ops - k0, 2);
      check(u_dev_card_model.got[k0], 16'hA5A5);
      check(u_dev_card_model.got[k0 + 1], 16'h5A5A);
      check(u_dev_card_model.sets - s0, 2);
      check(u_dev_card_model.clrs - c0, 0);
      check(irq, 1'b0);
      wr(`OFS_EN, 32'h0000_0001);
      rdc(`OFS_EN, 32'h0000_0001);
      check(irq, 1'b1);
      wr(`OFS_CLR, 32'h0000_0003);
      rdc(`OFS_STS, 32'h0000_0000);
      check(irq, 1'b0);
      wr(`OFS_CMD, 32'h0000_0008);
      $display("test output done");
   endtask : test_output
   task automatic test_output_clr();
      mem[34] = 16'h0F0F;
      setup(16'h2011, 16'h0022, 16'hFFFF, 8'h01);
      wr(`OFS_CMD, 32'h0000_0004);
      wait_done();
      check(u_dev_card_model.both - b0, 1);
      check(u_dev_card_model.ops - k0, 0);
      check(u_dev_card_model.got[k0], 16'h0F0F);
      wr(`OFS_CMD, 32'h0000_0008);
      $display("test output clear-control done");
   endtask : test_output_clr
   task automatic test_pack();
      logic [15:0] a, b;
      setup(16'hC00D, 16'h8030, 16'hFFFF, 8'h1E);
      start_device();
      wr(`OFS_CMD, 32'h0000_0004);
      wait_done();
      a = dev_word(k0);
      b = dev_word(k0 + 1);
      check({16'h0000, mem[48]}, {16'h0000, a[7:0], b[7:0]});
      rdc(`OFS_COUNT, 32'h0000_0000);
      wr(`OFS_CMD, 32'h0000_0008);
      $display("test packing done");
   endtask : test_pack
   task automatic test_pack_output();
      mem[36] = 16'hC3A5;
      setup(16'h4011, 16'h0024, 16'hFFFF, 8'h01);
      wr(`OFS_CMD, 32'h0000_0004);
      wait_done();
      for (int n = 0; n < 100 && u_dev_card_model.ops - k0 < 2; n++) begin
         @(posedge clk);
      end
      check(u_dev_card_model.ops - k0, 2);
      check(u_dev_card_model.sets - s0, 2);
      check(u_dev_card_model.got[k0], 16'h00C3);
      check(u_dev_card_model.got[k0 + 1], 16'h00A5);
      rdc(`OFS_COUNT, 32'h0000_0000);
      rdc(`OFS_ADDR, 32'h0000_0025);
      wr(`OFS_CMD, 32'h0000_0008);
      $display("test packed output done");
   endtask : test_pack_output
   task automatic complete_run();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      test_regs();
      test_input();
      test_output();
      test_output_clr();
      test_pack();
      test_pack_output();
      complete_run();
   end
   initial begin
      #100000;
      failures++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end
endmodule : testbench
